// *** design/hmfc_consts.vh ***
`ifndef HMFC_CONSTS_VH
`define HMFC_CONSTS_VH
`define HMFC_AW            8
`define HMFC_DW            32
`define HMFC_OFF_RX_CFG    8'h6C
`define HMFC_OFF_TX_CFG    8'h70
`define HMFC_OFF_RX_DP     8'h78
`define HMFC_OFF_STAT      8'hC0
`define HMFC_OFF_CLR       8'hC4
`define HMFC_OFF_EN        8'hC8
`define HMFC_OFF_TX_MON    8'hCC
`define HMFC_B_STOP        0
`define HMFC_B_TXON        1
`define HMFC_B_TX_STATUS_OVERRUN_ALLOW       2
`define HMFC_B_TXD_FLUSH   14
`define HMFC_B_TXS_FLUSH   15
`define HMFC_B_SKIP        31
`define HMFC_OFS_LSB       8
`define HMFC_OFS_MSB       12
`define HMFC_OFS_W         5
`define HMFC_OFS_RST       5'h00
`define HMFC_OFS_LO_W      2
`define HMFC_MON_TXS_LSB   16
`define HMFC_DEPTH_LOG2    4
`define HMFC_NIRQ          3
`define HMFC_IRQ_TX_STATUS_FULL_IRQ      0
`define HMFC_IRQ_STOPPED   1
`define HMFC_IRQ_SKIPDONE  2
`endif

// *** design/hmfc_ptr_fifo.v ***
`timescale 1ns/100ps
`include "hmfc_consts.vh"
// pointer/count tracker of a fifo; flush returns pointers to zero
module hmfc_ptr_fifo #(
   parameter AW = `HMFC_DEPTH_LOG2
) (
   input  wire          ref_clk_i,
   input  wire          rst_i,
   input  wire          flush_i,
   input  wire          push_i,
   input  wire          pop_i,
   output wire          full_o,
   output wire          empty_o,
   output wire [AW:0]   used_o
);
   reg [AW-1:0] wr_r;
   reg [AW-1:0] rd_r;
   reg [AW:0]   cnt_r;
   wire         do_push;
   wire         do_pop;
   assign full_o  = cnt_r[AW];
   assign empty_o = (cnt_r == {(AW+1){1'b0}});
   assign used_o  = cnt_r;
   assign do_push = push_i & ~full_o;
   assign do_pop  = pop_i & ~empty_o;
   always @(posedge ref_clk_i) begin
      if (rst_i || flush_i) begin
         wr_r  <= {AW{1'b0}};
         rd_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (do_push)
            wr_r <= wr_r + 1'b1;
         if (do_pop)
            rd_r <= rd_r + 1'b1;
         if (do_push && !do_pop)
            cnt_r <= cnt_r + 1'b1;
         else if (do_pop && !do_push)
            cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule // hmfc_ptr_fifo

// *** design/hmfc_irq.v ***
`timescale 1ns/100ps
`include "hmfc_consts.vh"
// sticky status, write-one-to-clear, enable mask, level output; set wins
module hmfc_irq #(
   parameter N = `HMFC_NIRQ
) (
   input  wire          ref_clk_i,
   input  wire          rst_i,
   input  wire [N-1:0]  event_i,
   input  wire          clr_we_i,
   input  wire          en_we_i,
   input  wire [N-1:0]  wdata_i,
   output reg  [N-1:0]  status_o,
   output reg  [N-1:0]  enable_o,
   output wire          irq_o
);
   assign irq_o = |(status_o & enable_o);
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         status_o <= {N{1'b0}};
         enable_o <= {N{1'b0}};
      end else begin
         status_o <= (status_o & ~(clr_we_i ? wdata_i : {N{1'b0}})) | event_i;
         if (en_we_i)
            enable_o <= wdata_i;
      end
   end
endmodule // hmfc_irq

// *** design/hmfc_ctrl.v ***
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "hmfc_consts.vh"
// Functional notes
// - rx data shifted by byte offset 0-31
// - offset upper bits apply from next word
// - tx status flush empties fifo, self-clears
// - tx data flush discards data, zeroes pointers
// - full status fifo pauses tx unless allowed
// - status full interrupt ignores overrun allow
// - enabled transmitter sends fifo data
// - enable clears when stop done, halted
// - stop ends at frame end or empty data fifo, then clears itself
// - stop writes ignored while stop set
// - frame skip advances rx, self-clears
module hmfc_ctrl #(
   parameter AW = `HMFC_DEPTH_LOG2
) (
   input  wire                   ref_clk_i,
   input  wire                   rst_i,
   input  wire [`HMFC_AW-1:0]    addr_i,
   input  wire [`HMFC_DW-1:0]    wdata_i,
   input  wire                   wr_i,
   input  wire                   rd_i,
   output reg  [`HMFC_DW-1:0]    rdata_o,
   input  wire                   txd_push_i,
   input  wire                   txd_eof_i,
   input  wire                   txs_pop_i,
   input  wire                   rxd_push_i,
   input  wire                   rxd_eof_i,
   input  wire                   rxd_pop_i,
   output wire                   tx_busy_o,
   output wire                   tx_word_o,
   output wire                   tx_eof_o,
   output wire [`HMFC_OFS_W-1:0] rx_byte_offset_o,
   output wire                   rx_skip_busy_o,
   output wire                   irq_o
);
   localparam ST_IDLE = 3'b001;
   localparam ST_SEND = 3'b010;
   localparam ST_HALT = 3'b100;

   reg  [2:0]               st_r;
   reg                      tx_on_r;
   reg                      stop_r;
   reg                      tx_status_overrun_allow_r;
   reg  [`HMFC_OFS_W-1:0]   ofs_r;
   reg  [1:0]               ofs_lo_live_r;
   reg  [2:0]               ofs_hi_live_r;
   reg                      skip_r;
   reg  [AW:0]              frames_r;
   reg  [AW-1:0]            rx_wp_r;
   reg  [AW-1:0]            rx_rp_r;
   reg                      rx_eof_mem [0:(1<<AW)-1];
   reg                      txs_full_d_r;
   reg                      tx_word_r;
   reg                      tx_eof_r;
   reg  [`HMFC_NIRQ-1:0]    ev;
   wire                     txd_full;
   wire                     txd_empty;
   wire                     txs_full;
   wire                     txs_empty;
   wire [AW:0]              txs_used;
   wire                     rxd_full;
   wire                     rxd_empty;
   wire [AW:0]              rxd_used;
   wire [AW:0]              txd_used;
   wire [`HMFC_NIRQ-1:0]    irq_stat;
   wire [`HMFC_NIRQ-1:0]    irq_en;
   wire                     wr_tx;
   wire                     wr_rx;
   wire                     wr_dp;
   wire                     txs_flush;
   wire                     txd_flush;
   wire                     pause;
   wire                     send_now;
   wire                     rx_pop_ok;
   wire                     rx_push_ok;
   wire                     rx_skip_pop;
   wire                     rx_any_pop;
   wire                     rx_head_eof;
   wire                     rx_eof_in;
   wire                     rx_eof_out;
   wire                     skip_done;
   wire                     wr_clr;
   wire                     wr_en;

   // register address decode
   function hit;
      input [`HMFC_AW-1:0] a;
      input [`HMFC_AW-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   assign wr_tx     = wr_i & hit(addr_i, `HMFC_OFF_TX_CFG);
   assign wr_rx     = wr_i & hit(addr_i, `HMFC_OFF_RX_CFG);
   assign wr_dp     = wr_i & hit(addr_i, `HMFC_OFF_RX_DP);
   assign txs_flush = wr_tx & wdata_i[`HMFC_B_TXS_FLUSH];
   assign txd_flush = wr_tx & wdata_i[`HMFC_B_TXD_FLUSH];
   // a full status fifo holds the transmitter unless overrun is allowed
   assign pause     = txs_full & ~tx_status_overrun_allow_r;
   assign send_now  = (st_r == ST_SEND) & ~txd_empty & ~pause;
   assign wr_clr    = wr_i & hit(addr_i, `HMFC_OFF_CLR);
   assign wr_en     = wr_i & hit(addr_i, `HMFC_OFF_EN);

   // host pops are refused while a skip runs
   assign rx_pop_ok   = rxd_pop_i & ~skip_r & ~rxd_empty;
   assign rx_push_ok  = rxd_push_i & ~rxd_full;
   // a skip drains only while a whole frame sits in the fifo
   assign rx_skip_pop = skip_r & ~rxd_empty & (frames_r != {(AW+1){1'b0}});
   assign rx_any_pop  = rx_pop_ok | rx_skip_pop;
   assign rx_head_eof = rx_eof_mem[rx_rp_r];
   assign rx_eof_in   = rx_push_ok & rxd_eof_i;
   assign rx_eof_out  = rx_any_pop & rx_head_eof;
   // ends once the last word of the head frame is gone, or at once if none
   assign skip_done   = skip_r & (~rx_skip_pop | rx_head_eof);

   hmfc_ptr_fifo #(.AW(AW)) u_txd (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .flush_i   (txd_flush),
      .push_i    (txd_push_i),
      .pop_i     (send_now),
      .full_o    (txd_full),
      .empty_o   (txd_empty),
      .used_o    (txd_used)
   );

   hmfc_ptr_fifo #(.AW(AW)) u_txs (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .flush_i   (txs_flush),
      .push_i    (send_now & txd_eof_i),
      .pop_i     (txs_pop_i),
      .full_o    (txs_full),
      .empty_o   (txs_empty),
      .used_o    (txs_used)
   );

   hmfc_ptr_fifo #(.AW(AW)) u_rxd (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .flush_i   (1'b0),
      .push_i    (rxd_push_i),
      .pop_i     (rx_any_pop),
      .full_o    (rxd_full),
      .empty_o   (rxd_empty),
      .used_o    (rxd_used)
   );

   hmfc_irq u_irq (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .event_i   (ev),
      .clr_we_i  (wr_clr),
      .en_we_i   (wr_en),
      .wdata_i   (wdata_i[`HMFC_NIRQ-1:0]),
      .status_o  (irq_stat),
      .enable_o  (irq_en),
      .irq_o     (irq_o)
   );

   // events: status fifo became full, transmitter halted, skip ended
   always @* begin
      ev = {`HMFC_NIRQ{1'b0}};
      ev[`HMFC_IRQ_TX_STATUS_FULL_IRQ] = txs_full & ~txs_full_d_r;
      ev[`HMFC_IRQ_STOPPED] = (st_r == ST_HALT);
      ev[`HMFC_IRQ_SKIPDONE] = skip_done;
   end

   always @(posedge ref_clk_i) begin
      if (rst_i)
         txs_full_d_r <= 1'b0;
      else
         txs_full_d_r <= txs_full;
   end

   // mirror of the rx fifo pointers; one end-of-frame flag per slot
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         rx_wp_r <= {AW{1'b0}};
         rx_rp_r <= {AW{1'b0}};
      end else begin
         if (rx_push_ok)
            rx_wp_r <= rx_wp_r + 1'b1;
         if (rx_any_pop)
            rx_rp_r <= rx_rp_r + 1'b1;
      end
   end

   always @(posedge ref_clk_i) begin
      if (rx_push_ok)
         rx_eof_mem[rx_wp_r] <= rxd_eof_i;
   end

   // transmitter control
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_r      <= ST_IDLE;
         tx_on_r   <= 1'b0;
         stop_r    <= 1'b0;
         tx_status_overrun_allow_r   <= 1'b0;
         tx_word_r <= 1'b0;
         tx_eof_r  <= 1'b0;
      end else begin
         tx_word_r <= send_now;
         tx_eof_r  <= send_now & txd_eof_i;
         if (wr_tx) begin
            tx_status_overrun_allow_r <= wdata_i[`HMFC_B_TX_STATUS_OVERRUN_ALLOW];
            if (!stop_r) begin
               stop_r  <= wdata_i[`HMFC_B_STOP];
               tx_on_r <= wdata_i[`HMFC_B_TXON];
            end else
               tx_on_r <= wdata_i[`HMFC_B_TXON] & tx_on_r;
         end
         case (st_r)
            ST_IDLE: begin
               if (tx_on_r && !stop_r)
                  st_r <= ST_SEND;
            end
            ST_SEND: begin
               // stop only at a frame boundary or once the data fifo is empty
               if (stop_r && (txd_empty || (send_now && txd_eof_i)))
                  st_r <= ST_HALT;
               else if (!tx_on_r)
                  st_r <= ST_IDLE;
            end
            ST_HALT: begin
               stop_r  <= 1'b0;
               tx_on_r <= 1'b0;
               st_r    <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
         // a stop requested while idle completes at once
         if (st_r == ST_IDLE && stop_r && !(tx_on_r && !stop_r)) begin
            stop_r  <= 1'b0;
            tx_on_r <= 1'b0;
         end
      end
   end

   // rx offset and frame skip
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         ofs_r         <= `HMFC_OFS_RST;
         ofs_lo_live_r <= 2'h0;
         ofs_hi_live_r <= 3'h0;
         skip_r        <= 1'b0;
         frames_r      <= {(AW+1){1'b0}};
      end else begin
         if (wr_rx)
            ofs_r <= wdata_i[`HMFC_OFS_MSB:`HMFC_OFS_LSB];
         ofs_lo_live_r <= ofs_r[`HMFC_OFS_LO_W-1:0];
         if (rx_pop_ok || rxd_empty)
            ofs_hi_live_r <= ofs_r[`HMFC_OFS_W-1:`HMFC_OFS_LO_W];
         // count of complete frames held in the rx fifo
         if (rx_eof_in && !rx_eof_out)
            frames_r <= frames_r + 1'b1;
         else if (rx_eof_out && !rx_eof_in)
            frames_r <= frames_r - 1'b1;
         if (wr_dp && wdata_i[`HMFC_B_SKIP] && !skip_r)
            skip_r <= 1'b1;
         else if (skip_done)
            skip_r <= 1'b0;
      end
   end

   assign tx_busy_o        = (st_r == ST_SEND);
   assign tx_word_o        = tx_word_r;
   assign tx_eof_o         = tx_eof_r;
   assign rx_byte_offset_o = {ofs_hi_live_r, ofs_lo_live_r};
   assign rx_skip_busy_o   = skip_r;

   // register read, one cycle later; reserved bits zero
   always @(posedge ref_clk_i) begin
      if (rst_i)
         rdata_o <= {`HMFC_DW{1'b0}};
      else if (rd_i) begin
         rdata_o <= {`HMFC_DW{1'b0}};
         case (addr_i)
            `HMFC_OFF_TX_CFG: begin
               rdata_o[`HMFC_B_TX_STATUS_OVERRUN_ALLOW] <= tx_status_overrun_allow_r;
               rdata_o[`HMFC_B_TXON]  <= tx_on_r;
               rdata_o[`HMFC_B_STOP]  <= stop_r;
            end
            `HMFC_OFF_RX_CFG: rdata_o[`HMFC_OFS_MSB:`HMFC_OFS_LSB] <= ofs_r;
            `HMFC_OFF_RX_DP:  rdata_o[`HMFC_B_SKIP] <= skip_r;
            `HMFC_OFF_STAT:   rdata_o[`HMFC_NIRQ-1:0] <= irq_stat;
            `HMFC_OFF_EN:     rdata_o[`HMFC_NIRQ-1:0] <= irq_en;
            `HMFC_OFF_TX_MON: begin
               rdata_o[`HMFC_MON_TXS_LSB+AW:`HMFC_MON_TXS_LSB] <= txs_used;
               rdata_o[AW:0]                                    <= txd_used;
            end
            default:          rdata_o <= {`HMFC_DW{1'b0}};
         endcase
      end
   end
endmodule // hmfc_ctrl

// *** verification/hmfc_ctrl_props.sv ***
`timescale 1ns/100ps
module hmfc_ctrl_props (
   input wire        ref_clk_i,
   input wire        rst_i,
   input wire [7:0]  addr_i,
   input wire [31:0] wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [31:0] rdata_o,
   input wire        tx_busy_o,
   input wire        tx_word_o,
   input wire [4:0]  rx_byte_offset_o,
   input wire        rx_skip_busy_o,
   input wire        irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_txcfg_rsvd: assert property (rd_i && addr_i == 8'h70 |=> rdata_o[31:3] == 29'h0)
      else $error("tx config unused bits read nonzero");
   a_rxcfg_rsvd: assert property (rd_i && addr_i == 8'h6C |=> rdata_o[7:0] == 8'h00 && rdata_o[14:13] == 2'h0)
      else $error("rx config reserved bits read nonzero");
   a_rxdp_rsvd: assert property (rd_i && addr_i == 8'h78 |=> rdata_o[30:0] == 31'h0)
      else $error("rx datapath reserved bits read nonzero");
   a_skip_read: assert property (rd_i && addr_i == 8'h78 |=> rdata_o[31] == $past(rx_skip_busy_o))
      else $error("skip bit read differs from skip state");
   a_skip_start: assert property (wr_i && addr_i == 8'h78 && wdata_i[31] && !rx_skip_busy_o |=> rx_skip_busy_o)
      else $error("skip write did not start skip");
   a_skip_bound: assert property ($rose(rx_skip_busy_o) |-> ##[1:16] !rx_skip_busy_o)
      else $error("skip never completed");
   a_word_busy: assert property (tx_word_o |-> $past(tx_busy_o))
      else $error("word sent outside send state");
   a_ofs_low: assert property (wr_i && addr_i == 8'h6C |-> ##2 rx_byte_offset_o[1:0] == $past(wdata_i[9:8], 2))
      else $error("offset low bits not applied");
   a_reset_idle: assert property (disable iff (1'b0) rst_i |=> !tx_busy_o && !rx_skip_busy_o && !irq_o && rdata_o == 32'h0)
      else $error("block not idle after reset");
endmodule // hmfc_ctrl_props

// *** verification/hmfc_rx_line.sv ***
`timescale 1ns/100ps
// line side: delivers one rx frame of len_i words, one word a cycle
module hmfc_rx_line (
   input  wire       ref_clk_i,
   input  wire       rst_i,
   input  wire       go_i,
   input  wire [3:0] len_i,
   output reg        rxd_push_o,
   output reg        rxd_eof_o
);
   reg [3:0] left_r;
   always @(posedge ref_clk_i) begin
      rxd_push_o <= 1'b0;
      rxd_eof_o  <= 1'b0;
      if (rst_i) begin
         left_r <= 4'h0;
      end else if (left_r != 4'h0) begin
         rxd_push_o <= 1'b1;
         rxd_eof_o  <= (left_r == 4'h1);
         left_r     <= left_r - 4'h1;
      end else if (go_i) begin
         left_r <= len_i;
      end
   end
endmodule // hmfc_rx_line

// *** verification/test_host_mac_fifo_tx_rx_control.sv ***
`timescale 1ns/100ps
module test_host_mac_fifo_tx_rx_control;
   reg         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, push_w = 1'b0, pop = 1'b0;
   reg         go = 1'b0, eof_head = 1'b1, txs_pop = 1'b0;
   reg  [3:0]  len = 4'h0;
   reg  [7:0]  addr = 8'h00;
   reg  [31:0] wdata = 32'h0, v;
   wire [31:0] rdata;
   wire [4:0]  ofs;
   wire        tx_busy, tx_word, tx_eof, skip_busy, irq, rx_push, rx_eof;
   integer     n_mismatch = 0, n_compared = 0, n_words = 0, n_eofs = 0, i;
   hmfc_ctrl i_dut (.ref_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .txd_push_i(push_w), .txd_eof_i(eof_head),
      .txs_pop_i(txs_pop), .rxd_push_i(rx_push), .rxd_eof_i(rx_eof), .rxd_pop_i(pop),
      .tx_busy_o(tx_busy), .tx_word_o(tx_word), .tx_eof_o(tx_eof), .rx_byte_offset_o(ofs),
      .rx_skip_busy_o(skip_busy), .irq_o(irq));
   hmfc_rx_line i_line (.ref_clk_i(clk), .rst_i(rst), .go_i(go), .len_i(len),
      .rxd_push_o(rx_push), .rxd_eof_o(rx_eof));
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (tx_word === 1'b1) n_words = n_words + 1;
      if (tx_eof === 1'b1) n_eofs = n_eofs + 1;
   end
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr_reg(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
         @(posedge clk); wr <= 1'b0;
      end
   endtask
   task rd_chk(input [7:0] a, input [31:0] m, input [31:0] e);
      begin
         @(posedge clk); addr <= a; rd <= 1'b1;
         @(posedge clk); rd <= 1'b0;
         #1 chk("rdata", e, rdata & m);
      end
   endtask
   task pulse(input integer n, input integer rx);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            @(posedge clk); if (rx) pop <= 1'b1; else push_w <= 1'b1;
            @(posedge clk); pop <= 1'b0; push_w <= 1'b0;
         end
      end
   endtask
   task wrap_up;
      begin
         $display("compared %0d mismatched %0d", n_compared, n_mismatch);
         if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      #(25 * 4000);
      n_mismatch = n_mismatch + 1;
      wrap_up;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 6; i = i + 1) rd_chk(48'h6C7078C0CC10 >> (40 - 8 * i), 32'hFF, 0);
      for (i = 0; i < 3; i = i + 1) begin
         v = (15'h7EA0 >> (10 - 5 * i)) & 32'h1F;
         wr_reg(8'h6C, 32'hFFFFE0FF | (v << 8));
         rd_chk(8'h6C, 32'h7FFF, v << 8);
         repeat (3) @(posedge clk);
         chk("offset", v, ofs);
      end
      $display("offset test done");
      wr_reg(8'h70, 32'hFFFFFFFE);
      rd_chk(8'h70, 32'hFFFFFFFF, 32'h6);
      pulse(3, 0);
      repeat (20) @(posedge clk);
      chk("words", 3, n_words);
      chk("frames", 3, n_eofs);
      rd_chk(8'hCC, 32'hFFFFFF, 32'h30000);
      wr_reg(8'h70, 32'h8006);
      rd_chk(8'hCC, 32'hFF0000, 0);
      wr_reg(8'h70, 32'h4);
      pulse(2, 0);
      rd_chk(8'hCC, 32'hFFFF, 2);
      wr_reg(8'h70, 32'h4004);
      rd_chk(8'hCC, 32'hFFFF, 0);
      chk("words", 3, n_words);
      $display("flush test done");
      wr_reg(8'hC8, 32'h7);
      wr_reg(8'h70, 32'h2);
      pulse(17, 0);
      repeat (30) @(posedge clk);
      rd_chk(8'hCC, 32'hFFFFFF, 32'h100001);
      rd_chk(8'hC0, 32'h1, 32'h1);
      chk("irq", 1, irq);
      wr_reg(8'hC4, 32'h7);
      #1 chk("irq", 0, irq);
      wr_reg(8'h70, 32'h6);
      repeat (10) @(posedge clk);
      rd_chk(8'hCC, 32'hFFFF, 0);
      wr_reg(8'h70, 32'h3);
      repeat (10) @(posedge clk);
      rd_chk(8'h70, 32'h3, 0);
      chk("irq", 1, irq);
      wr_reg(8'hC8, 32'h0);
      #1 chk("irq", 0, irq);
      $display("transmit test done");
      for (i = 3; i > 1; i = i - 1) begin
         @(posedge clk); go <= 1'b1; len <= i;
         @(posedge clk); go <= 1'b0;
         repeat (5) @(posedge clk);
      end
      wr_reg(8'h78, 32'h80000000);
      rd_chk(8'h78, 32'hFFFFFFFF, 32'h80000000);
      repeat (10) @(posedge clk);
      rd_chk(8'h78, 32'hFFFFFFFF, 0);
      wr_reg(8'h6C, 32'h800);
      repeat (3) @(posedge clk);
      chk("offset", 0, ofs);
      pulse(1, 1);
      repeat (2) @(posedge clk);
      chk("offset", 8, ofs);
      $display("skip test done");
      wrap_up;
   end
endmodule // test_host_mac_fifo_tx_rx_control
bind hmfc_ctrl hmfc_ctrl_props i_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_busy_o(tx_busy_o),
   .tx_word_o(tx_word_o), .rx_byte_offset_o(rx_byte_offset_o),
   .rx_skip_busy_o(rx_skip_busy_o), .irq_o(irq_o));
